// ==== hdl/twpot_pkg.sv ====
// shared constants of the two-wire potentiometer command decoder
package twpot_pkg;
  // instruction opcodes, high nibble of the instruction byte
  localparam logic [3:0] OP_RD_WIPER    = 4'h9;
  localparam logic [3:0] OP_WR_WIPER    = 4'hA;
  localparam logic [3:0] OP_RD_DATA     = 4'hB;
  localparam logic [3:0] OP_WR_DATA     = 4'hC;
  localparam logic [3:0] OP_XFR_TO_WIPR = 4'hD;
  localparam logic [3:0] OP_XFR_TO_DATA = 4'hE;
  localparam logic [3:0] OP_INCDEC      = 4'h2;
  // identification byte fields
  localparam int ID_MSB    = 7;
  localparam int ID_LSB    = 4;
  localparam int STRAP_MSB = 2;
  // instruction byte fields
  localparam int OPC_MSB  = 7;
  localparam int OPC_LSB  = 4;
  localparam int PTR_MSB  = 3;
  localparam int BANK_MSB = 1;
  localparam int BANK_LSB = 0;
  // arbitrary neutral device-type value, not a real part code
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'hA;
  // framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int         NUM_DATA_REGS = 16;
  // reset values and wiper limits
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [7:0] WIPER_MAX   = 8'hFF;
  localparam logic [7:0] WIPER_MIN   = 8'h00;
  // timing
  localparam int CLK_FREQ_KHZ     = 25000;
  localparam int NV_WRITE_TIME_US = 5000;
  localparam int NV_WRITE_MAX_US  = 10000;
  localparam int NV_WRITE_CYCLES  = NV_WRITE_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int NV_WRITE_MAX_CYC = NV_WRITE_MAX_US * CLK_FREQ_KHZ / 1000;
  localparam int BUSY_CNT_W       = 24;
  // synchroniser width: scl, sda, three straps, write protect
  localparam int SYNC_W = 6;
endpackage

// ==== hdl/twpot_sync.sv ====
// two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
`default_nettype none
module twpot_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1; // metastable catcher, read only by stage2
    logic [WIDTH-1:0] stage2; // safe level
  } twpot_sync_s;

  twpot_sync_s s;      // registered state
  twpot_sync_s next_s; // next state

  // shift the pins through both stages
  always_comb
  begin
    next_s        = s;
    next_s.stage1 = asyncIn;
    next_s.stage2 = s.stage1;
  end

  // constant reset to the idle high bus level, so no false edge follows reset
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '1;
    else
      s <= next_s;
  end

  assign syncOut = s.stage2;

endmodule
`default_nettype wire

// ==== hdl/twpot_decoder.sv ====
// two-wire slave command decoder of the digital potentiometer
//
// Function
// - transmitter releases data; receiver acks ninth clock
// - ack address, instruction, and data byte
// - stop after nv write starts busy cycle
// - no address ack while write busy
// - check device-type nibble of first byte
// - strap bits must match address bits
// - second byte: opcode, register and bank select
// - register select is binary, high bit first
// - sixteen registers in four banks, bank0 default
// - banks one to three never transfer
// - opcode 1001 reads wiper position
// - opcode 1010 writes wiper position
// - opcode 1011 reads selected data register
// - opcode 1100 writes selected data register
// - opcode 1101 copies bank0 register to wiper
// - opcode 1110 copies wiper to bank0 register
// - opcode 0010 enters increment/decrement mode
// - write protect low blocks nv writes
// - clock with data high steps up, low down
// - nv write finishes within ten milliseconds
`timescale 1ns/1ps
`default_nettype none
module twpot_decoder #(
  parameter logic [3:0] DEVICE_TYPE     = twpot_pkg::DEV_TYPE_DEFAULT,
  parameter int         NV_WRITE_CYCLES = twpot_pkg::NV_WRITE_CYCLES
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // two-wire bus, data is open drain
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // straps and protection pins
  input  wire logic [2:0] addressStrap,
  input  wire logic       writeProtectN,
  // status
  output logic [7:0]      wiperPosition,
  output logic            nvBusy,
  output logic            incDecActive
);

  typedef enum logic [3:0] {
    ST_IDLE,      // waiting for a start
    ST_ADDR,      // shifting identification byte
    ST_ADDR_ACK,  // acking the address
    ST_INSTR,     // shifting instruction byte
    ST_INSTR_ACK, // acking the instruction
    ST_TX,        // sending a register to the master
    ST_RX_DATA,   // shifting the data byte
    ST_DATA_ACK,  // acking the data byte
    ST_INCDEC,    // stepping the wiper per clock
    ST_IGNORE,    // deaf until next start or stop
    ST_BUSY       // internal nonvolatile write
  } twpot_state_e;

  typedef struct packed {
    twpot_state_e                            state;
    logic [3:0]                              bitCnt;   // bits seen in byte
    logic [7:0]                              shiftReg; // rx/tx shifter
    logic [3:0]                              opcode;   // latched opcode
    logic [3:0]                              regIdx;   // bank and register
    logic                                    sdaOe;    // pulling data low
    logic                                    sclPrev;  // for edge finding
    logic                                    sdaPrev;
    logic                                    nvPend;   // nv write awaits stop
    logic [3:0]                              nvIdx;    // target register
    logic [7:0]                              nvData;   // value to store
    logic [twpot_pkg::BUSY_CNT_W-1:0]        busyCnt;  // write cycle timer
    logic [7:0]                              wiper;    // wiper position
    logic [twpot_pkg::NUM_DATA_REGS-1:0][7:0] dataReg; // nv storage
  } twpot_core_s;

  localparam twpot_core_s CORE_RESET = '{
    state:   ST_IDLE,
    sclPrev: 1'b1, sdaPrev: 1'b1, // idle bus is high, no edge after reset
    wiper:   twpot_pkg::WIPER_RESET,
    dataReg: {twpot_pkg::NUM_DATA_REGS{twpot_pkg::DATA_RESET}},
    default: '0
  };

  twpot_core_s s;      // registered state
  twpot_core_s next_s; // next state

  // synchronised pins
  logic [twpot_pkg::SYNC_W-1:0] pinSync;
  logic       sclQ;
  logic       sdaQ;
  logic [2:0] strapQ;
  logic       wpNQ;

  // bus events from synchronised levels
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic addrMatch;

  // all pins pass two flops before any logic sees them
  twpot_sync #(
    .WIDTH (twpot_pkg::SYNC_W)
  ) uSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn ({scl, sdaIn, addressStrap, writeProtectN}),
    .syncOut (pinSync)
  );

  assign {sclQ, sdaQ, strapQ, wpNQ} = pinSync;

  // start/stop need scl high on both samples, so they never meet an scl edge
  assign sclRise = sclQ && !s.sclPrev;
  assign sclFall = !sclQ && s.sclPrev;
  assign startEv = sclQ && s.sclPrev && s.sdaPrev && !sdaQ;
  assign stopEv  = sclQ && s.sclPrev && !s.sdaPrev && sdaQ;

  // identification byte check on the completed shifter
  assign addrMatch =
    (s.shiftReg[twpot_pkg::ID_MSB:twpot_pkg::ID_LSB] == DEVICE_TYPE) &&
    (s.shiftReg[twpot_pkg::STRAP_MSB:0] == strapQ);

  // register pointer: register pair above bank pair
  function automatic logic [3:0] regPointer(input logic [7:0] instr);
    regPointer = instr[twpot_pkg::PTR_MSB:0];
  endfunction

  // legal opcode and pointer combinations
  function automatic logic instrLegal(input logic [7:0] instr);
    logic [3:0] op;
    op = instr[twpot_pkg::OPC_MSB:twpot_pkg::OPC_LSB];
    case (op)
      // pointer bits must all be zero
      twpot_pkg::OP_RD_WIPER,
      twpot_pkg::OP_WR_WIPER,
      twpot_pkg::OP_INCDEC:
        instrLegal = (instr[twpot_pkg::PTR_MSB:0] == 4'h0);
      // any bank, any register
      twpot_pkg::OP_RD_DATA,
      twpot_pkg::OP_WR_DATA:
        instrLegal = 1'b1;
      // transfers are bank 0 only
      twpot_pkg::OP_XFR_TO_WIPR,
      twpot_pkg::OP_XFR_TO_DATA:
        instrLegal = (instr[twpot_pkg::BANK_MSB:twpot_pkg::BANK_LSB] == 2'h0);
      default:
        instrLegal = 1'b0;
    endcase
  endfunction

  // bus sequencing, register updates and write cycle timing
  always_comb
  begin
    next_s         = s;
    next_s.sclPrev = sclQ;
    next_s.sdaPrev = sdaQ;
    if (s.state == ST_BUSY)
    begin
      // inputs are deaf for the whole write cycle
      next_s.sdaOe = 1'b0;
      if (s.busyCnt == '0)
        next_s.state = ST_IDLE;
      else
        next_s.busyCnt = s.busyCnt - 1'b1;
    end
    else if (startEv)
    begin
      // a start aborts anything outside the write cycle, even a half done command
      next_s.state  = ST_ADDR;
      next_s.bitCnt = 4'h0;
      next_s.sdaOe  = 1'b0;
      next_s.nvPend = 1'b0;
    end
    else if (stopEv)
    begin
      next_s.sdaOe  = 1'b0;
      next_s.nvPend = 1'b0;
      next_s.state  = ST_IDLE;
      // protected writes are dropped silently, no busy cycle follows
      if (s.nvPend && wpNQ)
      begin
        next_s.dataReg[s.nvIdx] = s.nvData;
        next_s.state   = ST_BUSY;
        next_s.busyCnt = twpot_pkg::BUSY_CNT_W'(NV_WRITE_CYCLES - 1);
      end
    end
    else
    begin
      // receiving states shift on the rising clock
      if (sclRise && (s.state == ST_ADDR || s.state == ST_INSTR ||
                      s.state == ST_RX_DATA))
      begin
        next_s.shiftReg = {s.shiftReg[6:0], sdaQ};
        next_s.bitCnt   = s.bitCnt + 4'h1;
      end
      case (s.state)
        ST_ADDR:
        begin
          // eighth bit in: answer during the ninth clock
          if (sclFall && s.bitCnt == twpot_pkg::BITS_PER_BYTE)
          begin
            next_s.bitCnt = 4'h0;
            if (addrMatch)
            begin
              next_s.sdaOe = 1'b1;
              next_s.state = ST_ADDR_ACK;
            end
            else
              next_s.state = ST_IGNORE;
          end
        end
        ST_ADDR_ACK, ST_DATA_ACK:
        begin
          // release after the ninth clock
          if (sclFall)
          begin
            next_s.sdaOe = 1'b0;
            next_s.state = (s.state == ST_ADDR_ACK) ? ST_INSTR : ST_IGNORE;
          end
        end
        ST_INSTR:
        begin
          if (sclFall && s.bitCnt == twpot_pkg::BITS_PER_BYTE)
          begin
            next_s.bitCnt = 4'h0;
            next_s.opcode = s.shiftReg[twpot_pkg::OPC_MSB:twpot_pkg::OPC_LSB];
            next_s.regIdx = regPointer(s.shiftReg);
            if (instrLegal(s.shiftReg))
            begin
              next_s.sdaOe = 1'b1;
              next_s.state = ST_INSTR_ACK;
              // transfers act on the instruction itself
              if (s.shiftReg[7:4] == twpot_pkg::OP_XFR_TO_WIPR)
                next_s.wiper = s.dataReg[regPointer(s.shiftReg)];
              if (s.shiftReg[7:4] == twpot_pkg::OP_XFR_TO_DATA)
              begin
                next_s.nvPend = 1'b1;
                next_s.nvIdx  = regPointer(s.shiftReg);
                next_s.nvData = s.wiper;
              end
            end
            else
              next_s.state = ST_IGNORE;
          end
        end
        ST_INSTR_ACK:
        begin
          if (sclFall)
          begin
            next_s.sdaOe = 1'b0;
            case (s.opcode)
              twpot_pkg::OP_RD_WIPER, twpot_pkg::OP_RD_DATA:
              begin
                // load and present the first bit right away
                next_s.shiftReg = (s.opcode == twpot_pkg::OP_RD_WIPER) ?
                                  s.wiper : s.dataReg[s.regIdx];
                next_s.sdaOe    = !next_s.shiftReg[7];
                next_s.state    = ST_TX;
              end
              twpot_pkg::OP_WR_WIPER, twpot_pkg::OP_WR_DATA:
                next_s.state = ST_RX_DATA;
              twpot_pkg::OP_INCDEC:
                next_s.state = ST_INCDEC;
              default:
                next_s.state = ST_IGNORE;
            endcase
          end
        end
        ST_TX:
        begin
          if (sclRise)
            next_s.bitCnt = s.bitCnt + 4'h1;
          if (sclFall)
          begin
            if (s.bitCnt == twpot_pkg::BITS_PER_BYTE)
            begin
              // master acks the ninth clock; one byte per read
              next_s.sdaOe = 1'b0;
              next_s.state = ST_IGNORE;
            end
            else
            begin
              next_s.sdaOe    = !s.shiftReg[6];
              next_s.shiftReg = {s.shiftReg[6:0], 1'b0};
            end
          end
        end
        ST_RX_DATA:
        begin
          if (sclFall && s.bitCnt == twpot_pkg::BITS_PER_BYTE)
          begin
            next_s.bitCnt = 4'h0;
            next_s.sdaOe  = 1'b1;
            next_s.state  = ST_DATA_ACK;
            if (s.opcode == twpot_pkg::OP_WR_WIPER)
              next_s.wiper = s.shiftReg;
            else
            begin
              // stored only when the stop arrives
              next_s.nvPend = 1'b1;
              next_s.nvIdx  = s.regIdx;
              next_s.nvData = s.shiftReg;
            end
          end
        end
        ST_INCDEC:
        begin
          // saturate at the ends instead of wrapping
          if (sclRise)
          begin
            if (sdaQ && s.wiper != twpot_pkg::WIPER_MAX)
              next_s.wiper = s.wiper + 8'h01;
            else if (!sdaQ && s.wiper != twpot_pkg::WIPER_MIN)
              next_s.wiper = s.wiper - 8'h01;
          end
        end
        default:
        begin
          // idle and ignore wait for a start
          next_s.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= CORE_RESET;
    else
      s <= next_s;
  end

  // open drain: only ever pulls low
  assign sdaOut        = 1'b0;
  assign sdaOe         = s.sdaOe;
  assign wiperPosition = s.wiper;
  assign nvBusy        = (s.state == ST_BUSY);
  assign incDecActive  = (s.state == ST_INCDEC);

  // helpers read only by the checks below
  logic [7:0] selData;
  logic [7:0] nvSlot;
  assign selData = s.dataReg[s.regIdx];
  assign nvSlot  = s.dataReg[s.nvIdx];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence sAddrEnd;
    s.state == ST_ADDR && sclFall && s.bitCnt == twpot_pkg::BITS_PER_BYTE;
  endsequence

  sequence sStopCommit;
    s.state != ST_BUSY && !startEv && stopEv && s.nvPend && wpNQ;
  endsequence

  sequence sReadLoad;
    s.state == ST_INSTR_ACK && sclFall && !startEv && !stopEv;
  endsequence

  a_addr_ack: assert property (
    sAddrEnd ##0 addrMatch |=> s.sdaOe && s.state == ST_ADDR_ACK)
    else $error("address match not acknowledged");

  a_addr_reject: assert property (
    sAddrEnd ##0 !addrMatch |=> !s.sdaOe && s.state == ST_IGNORE)
    else $error("address mismatch not ignored");

  a_ack_release: assert property (
    (s.state == ST_DATA_ACK && sclFall) |=> !s.sdaOe ##1 !s.sdaOe)
    else $error("ack not released after ninth clock");

  a_busy_quiet: assert property (
    s.state == ST_BUSY |-> !s.sdaOe)
    else $error("ack driven during write cycle");

  a_stop_commit: assert property (
    sStopCommit |=> s.state == ST_BUSY && nvSlot == $past(s.nvData))
    else $error("stop did not start write cycle");

  a_busy_bound: assert property (
    s.state == ST_BUSY |-> s.busyCnt < twpot_pkg::NV_WRITE_MAX_CYC)
    else $error("write cycle longer than allowed");

  a_wp_block: assert property (
    !wpNQ |=> $stable(s.dataReg))
    else $error("data register changed while protected");

  a_wiper_read: assert property (
    sReadLoad ##0 s.opcode == twpot_pkg::OP_RD_WIPER
      |=> s.shiftReg == $past(s.wiper) && s.sdaOe == !s.shiftReg[7])
    else $error("wiper read loaded wrong value");

  a_data_read: assert property (
    sReadLoad ##0 s.opcode == twpot_pkg::OP_RD_DATA
      |=> s.shiftReg == $past(selData))
    else $error("data read loaded wrong value");

  a_wiper_write: assert property (
    (s.state == ST_RX_DATA && sclFall && s.opcode == twpot_pkg::OP_WR_WIPER &&
     s.bitCnt == twpot_pkg::BITS_PER_BYTE) |=> s.wiper == $past(s.shiftReg))
    else $error("wiper write lost");

  a_step_up: assert property (
    (s.state == ST_INCDEC && sclRise && !startEv && !stopEv && sdaQ &&
     s.wiper != twpot_pkg::WIPER_MAX) |=> s.wiper == $past(s.wiper) + 8'h01)
    else $error("increment step missing");

endmodule
`default_nettype wire

// ==== sim/twpot_master_model.sv ====
// bus master model driving the two-wire clock and data pins
`timescale 1ns/1ps
`default_nettype none
module twpot_master_model (
  // launch alignment
  input  wire logic sys_clk,
  // bus pins, data wire resolved outside
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sdaWire
);
  // clock stands high and data released outside frames
  initial
  begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end
  // every sequence launches just after a system clock edge
  task automatic align();
    @(posedge sys_clk);
    #1;
  endtask
  // start, or repeated start while the clock is low
  task automatic start();
    align();
    if (!scl)
    begin
      sdaLow = 1'b0;
      #200 scl = 1'b1;
      #120;
    end
    sdaLow = 1'b1;
    #120 scl = 1'b0;
  endtask
  // stop leaves both lines high
  task automatic stop();
    align();
    sdaLow = 1'b1;
    #200 scl = 1'b1;
    #120 sdaLow = 1'b0;
    #120;
  endtask
  // one clock pulse, data only moves while the clock is low
  task automatic pulse(input logic bitVal, output logic seen);
    #40 sdaLow = ~bitVal;
    #160 scl = 1'b1;
    #60 seen = sdaWire;
    #60 scl = 1'b0;
  endtask
  // eight bits msb first, then release for the ninth clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask
  // device sends eight bits; master answers with a release
  task automatic recv_byte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(1'b1, s);
  endtask
  // poll start plus address until answered, bounded tries
  task automatic poll(input logic [7:0] id, output logic ack, output int tries);
    ack   = 1'b0;
    tries = 0;
    while (!ack && tries < 8)
    begin
      start();
      send_byte(id, ack);
      stop();
      tries++;
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench of the two-wire potentiometer command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int         NV_CYC   = 200;  // shortened write cycle
  localparam logic [3:0] DEV_TYPE = 4'h6; // arbitrary device-type value
  localparam logic [2:0] STRAP    = 3'h5;
  localparam logic [7:0] ID       = {DEV_TYPE, 1'b0, STRAP};
  // clock, reset and pins
  logic       sys_clk;
  logic       rst_n;
  logic       scl;
  logic       sdaLow;
  logic       sdaOut;
  logic       sdaOe;
  logic [2:0] addressStrap;
  logic       writeProtectN;
  logic [7:0] wiperPosition;
  logic       nvBusy;
  logic       incDecActive;
  wire        sdaWire;
  // bench state
  int         miscompares;
  int         compares;
  int         cycles;
  int         busyRun;
  int         busyLen;
  int         tries;
  logic       ack;
  logic [7:0] acks;
  logic [7:0] rd;
  logic [3:0] idx [3] = '{4'hC, 4'h6, 4'hF}; // C is register 3 of bank 0
  // wired-and data line with pull-up
  assign sdaWire = ~sdaLow & (sdaOe ? sdaOut : 1'b1);
  twpot_decoder #(
    .DEVICE_TYPE     (DEV_TYPE),
    .NV_WRITE_CYCLES (NV_CYC)
  ) u_twpot_decoder (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .scl           (scl),
    .sdaIn         (sdaWire),
    .sdaOut        (sdaOut),
    .sdaOe         (sdaOe),
    .addressStrap  (addressStrap),
    .writeProtectN (writeProtectN),
    .wiperPosition (wiperPosition),
    .nvBusy        (nvBusy),
    .incDecActive  (incDecActive)
  );
  twpot_master_model u_twpot_master_model (
    .sys_clk (sys_clk),
    .scl     (scl),
    .sdaLow  (sdaLow),
    .sdaWire (sdaWire)
  );
  // 25 MHz system clock
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  // busy run length and hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (nvBusy === 1'b1)
      busyRun++;
    else if (busyRun != 0)
    begin
      busyLen = busyRun;
      busyRun = 0;
    end
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  // compare and report
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one frame; mode 0 two bytes, 1 write data, 2 read data
  task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, input int mode);
    u_twpot_master_model.start();
    u_twpot_master_model.send_byte(ID, ack);
    acks = {7'h00, ack};
    u_twpot_master_model.send_byte(ins, ack);
    acks = acks + {7'h00, ack};
    if (mode == 1)
    begin
      u_twpot_master_model.send_byte(dat, ack);
      acks = acks + {7'h00, ack};
    end
    if (mode == 2)
      u_twpot_master_model.recv_byte(rd);
    u_twpot_master_model.stop();
    // let the stop pass the synchroniser, then sample off the edge
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // wait out a write cycle by polling
  task automatic poll_busy();
    // only the length of this write cycle counts
    busyLen = 0;
    check({7'h00, nvBusy}, 8'h01);
    u_twpot_master_model.poll(ID, ack, tries);
    check({7'h00, ack}, 8'h01);
    check({7'h00, tries > 1}, 8'h01);
    check(busyLen[7:0], 8'hC8);
  endtask
  // closing report
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {miscompares, compares, cycles, busyRun, busyLen} = '0;
    rst_n         = 1'b0;
    addressStrap  = STRAP;
    writeProtectN = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    // wiper write and read back, pot bank bit zero
    xfer(8'hA0, 8'h5A, 1);
    check(acks, 8'h03);
    check(wiperPosition, 8'h5A);
    xfer(8'h90, 8'h00, 2);
    check(rd, 8'h5A);
    $display("test wiper access done");
    // data registers across banks
    foreach (idx[i])
    begin
      xfer({4'hC, idx[i]}, {idx[i], ~idx[i]}, 1);
      check(acks, 8'h03);
      poll_busy();
      xfer({4'hB, idx[i]}, 8'h00, 2);
      check(rd, {idx[i], ~idx[i]});
    end
    $display("test data registers done");
    // transfers, bank 0 only; register 3 of bank 0 holds C3
    xfer(8'hDC, 8'h00, 0);
    check(acks, 8'h02);
    check(wiperPosition, 8'hC3);
    xfer(8'hD6, 8'h00, 0);
    check(acks, 8'h01);
    check(wiperPosition, 8'hC3);
    xfer(8'hE4, 8'h00, 0);
    check(acks, 8'h02);
    poll_busy();
    xfer(8'hB4, 8'h00, 2);
    check(rd, 8'hC3);
    $display("test transfers done");
    // protected write is dropped
    @(posedge sys_clk);
    #1 writeProtectN = 1'b0;
    xfer(8'hC4, 8'h77, 1);
    check({7'h00, nvBusy}, 8'h00);
    xfer(8'hB4, 8'h00, 2);
    check(rd, 8'hC3);
    @(posedge sys_clk);
    #1 writeProtectN = 1'b1;
    $display("test write protect done");
    // wrong strap bits, then wrong type; device stays deaf
    foreach (idx[i])
    begin
      if (i < 2)
      begin
        u_twpot_master_model.start();
        u_twpot_master_model.send_byte(i == 0 ? ID ^ 8'h01 : ID ^ 8'h90, ack);
        check({7'h00, ack}, 8'h00);
        u_twpot_master_model.send_byte(8'hA0, ack);
        check({7'h00, ack}, 8'h00);
        u_twpot_master_model.send_byte(8'h11, ack);
        u_twpot_master_model.stop();
      end
    end
    check(wiperPosition, 8'hC3);
    $display("test address refusal done");
    // stepping with saturation at the top
    xfer(8'hA0, 8'hFE, 1);
    u_twpot_master_model.start();
    u_twpot_master_model.send_byte(ID, ack);
    u_twpot_master_model.send_byte(8'h20, ack);
    check({7'h00, ack}, 8'h01);
    u_twpot_master_model.pulse(1'b1, ack);
    u_twpot_master_model.pulse(1'b1, ack);
    u_twpot_master_model.pulse(1'b0, ack);
    check({7'h00, incDecActive}, 8'h01);
    check(wiperPosition, 8'hFE);
    // the stop's own clock pulse has data low and steps down once more
    u_twpot_master_model.stop();
    repeat (4) @(posedge sys_clk);
    #1;
    check(wiperPosition, 8'hFD);
    check({7'h00, incDecActive}, 8'h00);
    $display("test increment decrement done");
    print_verdict();
  end
endmodule
`default_nettype wire
